// ==== rtl/count_step_down.sv ====
// One-step down counter in binary or four-digit decimal code.
// Assumes the caller applies the step only on its own clock enable.
`timescale 1ns/1ps

module count_step_down (
  // Current count and code
  input  wire logic [15:0] count_in,
  input  wire logic        decimal,
  // Count less one
  output logic [15:0]      count_out
);

  logic [3:0]  borrow;
  logic [15:0] dec_val;

  assign borrow[0] = 1'b1;

  // ----------------------------------------------------------
  // Decimal digit chain; zero wraps to 9999
  // ----------------------------------------------------------
  genvar d;
  generate
    for (d = 0; d < 4; d++) begin : g_digit
      logic [3:0] dig;
      assign dig = count_in[d*4 +: 4];
      assign dec_val[d*4 +: 4] = !borrow[d] ? dig :
                                 (dig == 4'h0) ? 4'h9 : dig - 4'h1;
      if (d < 3) begin : g_borrow
        assign borrow[d+1] = borrow[d] && (dig == 4'h0);
      end
    end
  endgenerate

  // Binary zero wraps to 65535
  assign count_out = decimal ? dec_val : count_in - 16'h0001;

endmodule // count_step_down

// ==== rtl/pacer_counters_map.svh ====
// Offsets, field positions, reset values and timing counts of the counter block.
// Assumes an 8-bit byte-wide host port addressed by the low byte of the offset.
`ifndef PACER_COUNTERS_MAP_SVH
`define PACER_COUNTERS_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CNT0_PORT_OFF  8'h40
`define CNT1_PORT_OFF  8'h42
`define CNT2_PORT_OFF  8'h44
`define CTRL_WORD_OFF  8'h46

// ------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------
`define SEL_HI_BIT     7
`define SEL_LO_BIT     6
`define ACC_HI_BIT     5
`define ACC_LO_BIT     4
`define MODE_HI_BIT    3
`define MODE_LO_BIT    1
`define DECIMAL_BIT    0
`define SEL_ILLEGAL    2'h3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define COUNT_RESET    16'h0000
`define RDATA_RESET    8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_HZ         40000000
`define BASE_HZ        2000000
`define BASE_DIV       (`CLK_HZ / `BASE_HZ)

`endif

// ==== rtl/pacer_counters_pkg.sv ====
// Types shared by the counter block.
// Assumes the map header supplies all numeric constants.
package pacer_counters_pkg;

  // ----------------------------------------------------------
  // Operating modes and byte access kinds
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ZERO,
    MODE_ONE,
    MODE_TWO,
    MODE_THREE,
    MODE_FOUR,
    MODE_FIVE
  } op_mode_t;

  typedef enum logic [1:0] {
    ACC_LATCH,
    ACC_LOW,
    ACC_HIGH,
    ACC_LOW_HIGH
  } access_t;

endpackage

// ==== rtl/pacer_pretrigger_counters.sv ====
// Three-channel interval counter block with chained pacer and pre-trigger stop.
// Assumes host strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`include "pacer_counters_map.svh"

module pacer_pretrigger_counters (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Host byte port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Trigger control
  input  wire logic       ad_src_ext_sel,
  input  wire logic       ext_ad_trigger,
  input  wire logic       pretrigger_mode_en,
  input  wire logic       pretrigger_input,
  // Interrupt source
  input  wire logic       irq_src_pacer_sel,
  input  wire logic       ext_irq_input,
  // Results
  output logic            ad_trigger,
  output logic            pacer_out,
  output logic            second_irq_line,
  output logic            ad_stopped
);

  localparam int NCH = 3;

  // ----------------------------------------------------------
  // Channel state
  // ----------------------------------------------------------
  logic [15:0]                    count_reg   [NCH];
  logic [15:0]                    reload_reg  [NCH];
  logic [15:0]                    latch_reg   [NCH];
  pacer_counters_pkg::op_mode_t   mode_reg    [NCH];
  pacer_counters_pkg::access_t    acc_reg     [NCH];
  logic                           dec_reg     [NCH];
  logic                           out_reg     [NCH];
  logic                           armed_reg   [NCH];
  logic                           load_reg    [NCH];
  logic                           trig_reg    [NCH];
  logic                           gprev_reg   [NCH];
  logic                           latched_reg [NCH];
  logic                           wptr_reg    [NCH];
  logic                           rptr_reg    [NCH];
  logic                           zero_reg    [NCH];
  logic [15:0]                    dec1        [NCH];
  logic [15:0]                    dec2        [NCH];
  logic [NCH-1:0]                 ce;
  logic [NCH-1:0]                 gate;

  // ----------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------
  logic [4:0] base_cnt_reg;
  logic       base_tick_reg;
  logic       out1_prev_reg;
  logic       out2_prev_reg;
  logic       pt_prev_reg;
  logic       gate0_reg;
  logic       stop_reg;
  logic       ad_trig_reg;
  logic       irq2_reg;
  logic [7:0] rdata_reg;
  logic       ctrl_wr;
  logic       pacer_rise;
  logic       pt_fall;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------
  // Control word decode
  // ----------------------------------------------------------
  function automatic pacer_counters_pkg::op_mode_t mode_of(input logic [2:0] m);
    if (m[1:0] == 2'h2)
      return pacer_counters_pkg::MODE_TWO;
    if (m[1:0] == 2'h3)
      return pacer_counters_pkg::MODE_THREE;
    unique case (m)
      3'h0:    return pacer_counters_pkg::MODE_ZERO;
      3'h1:    return pacer_counters_pkg::MODE_ONE;
      3'h4:    return pacer_counters_pkg::MODE_FOUR;
      default: return pacer_counters_pkg::MODE_FIVE;
    endcase
  endfunction

  function automatic pacer_counters_pkg::access_t acc_of(input logic [1:0] a);
    unique case (a)
      2'h0:    return pacer_counters_pkg::ACC_LATCH;
      2'h1:    return pacer_counters_pkg::ACC_LOW;
      2'h2:    return pacer_counters_pkg::ACC_HIGH;
      default: return pacer_counters_pkg::ACC_LOW_HIGH;
    endcase
  endfunction

  assign ctrl_wr = reg_wr && (reg_addr == `CTRL_WORD_OFF);

  // ----------------------------------------------------------
  // Base clock enable, 2 MHz from the system clock
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      base_cnt_reg  <= 5'h00;
      base_tick_reg <= 1'b0;
    end else if (base_cnt_reg == 5'(`BASE_DIV - 1)) begin
      base_cnt_reg  <= 5'h00;
      base_tick_reg <= 1'b1;
    end else begin
      base_cnt_reg  <= base_cnt_reg + 5'h01;
      base_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Channel clocks and gates
  // ----------------------------------------------------------
  assign ce[0]   = ad_trig_reg;
  assign ce[1]   = base_tick_reg;
  assign ce[2]   = out_reg[1] && !out1_prev_reg;
  assign gate[0] = gate0_reg;
  assign gate[1] = 1'b1;
  assign gate[2] = 1'b1;

  // ----------------------------------------------------------
  // Counter channels
  // ----------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic wr_hit;
      logic rd_hit;
      logic cw_hit;
      logic tc;

      assign wr_hit = reg_wr && (reg_addr == 8'(`CNT0_PORT_OFF + 2 * i));
      assign rd_hit = reg_rd && (reg_addr == 8'(`CNT0_PORT_OFF + 2 * i));
      assign cw_hit = ctrl_wr && (reg_wdata[`SEL_HI_BIT:`SEL_LO_BIT] == 2'(i));
      assign tc     = (count_reg[i] == 16'h0001);

      count_step_down u_dec1 (
        .count_in  (count_reg[i]),
        .decimal   (dec_reg[i]),
        .count_out (dec1[i])
      );
      count_step_down u_dec2 (
        .count_in  (dec1[i]),
        .decimal   (dec_reg[i]),
        .count_out (dec2[i])
      );

      always_ff @(posedge clk) begin
        if (!nrst) begin
          count_reg[i]   <= `COUNT_RESET;
          reload_reg[i]  <= `COUNT_RESET;
          latch_reg[i]   <= `COUNT_RESET;
          mode_reg[i]    <= pacer_counters_pkg::MODE_ZERO;
          acc_reg[i]     <= pacer_counters_pkg::ACC_LOW_HIGH;
          dec_reg[i]     <= 1'b0;
          out_reg[i]     <= 1'b1;
          armed_reg[i]   <= 1'b0;
          load_reg[i]    <= 1'b0;
          trig_reg[i]    <= 1'b0;
          gprev_reg[i]   <= 1'b0;
          latched_reg[i] <= 1'b0;
          wptr_reg[i]    <= 1'b0;
          rptr_reg[i]    <= 1'b0;
          zero_reg[i]    <= 1'b0;
        end else begin
          gprev_reg[i] <= gate[i];
          zero_reg[i] <= ce[i] && armed_reg[i] && gate[i] && tc;
          // Counting engine, one step per channel enable, two steps in mode 3
          if (ce[i]) begin
            if (!armed_reg[i] && !out_reg[i] &&
                (mode_reg[i] == pacer_counters_pkg::MODE_FOUR ||
                 mode_reg[i] == pacer_counters_pkg::MODE_FIVE))
              out_reg[i] <= 1'b1;
            if (trig_reg[i] &&
                (mode_reg[i] == pacer_counters_pkg::MODE_ONE ||
                 mode_reg[i] == pacer_counters_pkg::MODE_FIVE)) begin
              trig_reg[i]  <= 1'b0;
              count_reg[i] <= reload_reg[i];
              armed_reg[i] <= 1'b1;
              out_reg[i]   <= (mode_reg[i] == pacer_counters_pkg::MODE_FIVE);
            end else if (load_reg[i] && (!armed_reg[i] ||
                         mode_reg[i] == pacer_counters_pkg::MODE_ZERO ||
                         mode_reg[i] == pacer_counters_pkg::MODE_FOUR)) begin
              load_reg[i]  <= 1'b0;
              count_reg[i] <= reload_reg[i];
              armed_reg[i] <= 1'b1;
            end else if (armed_reg[i]) begin
              unique case (mode_reg[i])
                pacer_counters_pkg::MODE_ZERO: begin
                  if (gate[i]) begin
                    count_reg[i] <= dec1[i];
                    if (tc)
                      out_reg[i] <= 1'b1;
                  end
                end
                pacer_counters_pkg::MODE_ONE: begin
                  count_reg[i] <= dec1[i];
                  if (tc) begin
                    out_reg[i]   <= 1'b1;
                    armed_reg[i] <= 1'b0;
                  end
                end
                pacer_counters_pkg::MODE_TWO: begin
                  // Low for one period before reload
                  if (gate[i]) begin
                    if (tc) begin
                      out_reg[i]   <= 1'b1;
                      count_reg[i] <= reload_reg[i];
                      load_reg[i]  <= 1'b0;
                    end else begin
                      out_reg[i]   <= (count_reg[i] != 16'h0002);
                      count_reg[i] <= dec1[i];
                    end
                  end
                end
                pacer_counters_pkg::MODE_THREE: begin
                  // Odd counts run one step long; both half periods stay equal
                  if (gate[i]) begin
                    if (count_reg[i] == 16'h0002 || tc) begin
                      out_reg[i]   <= !out_reg[i];
                      count_reg[i] <= reload_reg[i];
                      load_reg[i]  <= 1'b0;
                    end else
                      count_reg[i] <= dec2[i];
                  end
                end
                default: begin
                  // Modes 4 and 5: one low strobe at terminal count
                  if (gate[i] || mode_reg[i] == pacer_counters_pkg::MODE_FIVE) begin
                    count_reg[i] <= dec1[i];
                    if (tc) begin
                      out_reg[i]   <= 1'b0;
                      armed_reg[i] <= 1'b0;
                    end
                  end
                end
              endcase
            end
          end
          // Host side wins over the engine in the same cycle
          if (cw_hit) begin
            if (reg_wdata[`ACC_HI_BIT:`ACC_LO_BIT] == 2'h0) begin
              if (!latched_reg[i]) begin
                latch_reg[i]   <= count_reg[i];
                latched_reg[i] <= 1'b1;
              end
            end else begin
              acc_reg[i]   <= acc_of(reg_wdata[`ACC_HI_BIT:`ACC_LO_BIT]);
              mode_reg[i]  <= mode_of(reg_wdata[`MODE_HI_BIT:`MODE_LO_BIT]);
              dec_reg[i]   <= reg_wdata[`DECIMAL_BIT];
              wptr_reg[i]  <= 1'b0;
              rptr_reg[i]  <= 1'b0;
              out_reg[i]   <= (reg_wdata[`MODE_HI_BIT:`MODE_LO_BIT] != 3'h0);
              armed_reg[i] <= 1'b0;
              load_reg[i]  <= 1'b0;
              trig_reg[i]  <= 1'b0;
            end
          end else if (wr_hit) begin
            unique case (acc_reg[i])
              pacer_counters_pkg::ACC_LOW: begin
                reload_reg[i] <= {8'h00, reg_wdata};
                load_reg[i]   <= 1'b1;
              end
              pacer_counters_pkg::ACC_HIGH: begin
                reload_reg[i] <= {reg_wdata, 8'h00};
                load_reg[i]   <= 1'b1;
              end
              default: begin
                if (!wptr_reg[i])
                  reload_reg[i][7:0] <= reg_wdata;
                else begin
                  reload_reg[i][15:8] <= reg_wdata;
                  load_reg[i]         <= 1'b1;
                end
                wptr_reg[i] <= !wptr_reg[i];
              end
            endcase
            if (mode_reg[i] == pacer_counters_pkg::MODE_ZERO &&
                (acc_reg[i] != pacer_counters_pkg::ACC_LOW_HIGH || !wptr_reg[i]))
              out_reg[i] <= 1'b0;
          end else if (rd_hit) begin
            if (acc_reg[i] == pacer_counters_pkg::ACC_LOW_HIGH)
              rptr_reg[i] <= !rptr_reg[i];
            if (acc_reg[i] != pacer_counters_pkg::ACC_LOW_HIGH || rptr_reg[i])
              latched_reg[i] <= 1'b0;
          end
          // Gate rise arms the triggered modes; set wins over any clear
          if (gate[i] && !gprev_reg[i])
            trig_reg[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // Read data; control word and unmapped offsets read zero
  // ----------------------------------------------------------
  always_comb begin
    logic [1:0]  ch;
    logic [15:0] src;
    logic        hi;
    ch      = reg_addr[2:1];
    rd_byte = 8'h00;
    src     = 16'h0000;
    hi      = 1'b0;
    if (reg_addr[7:3] == 5'(`CNT0_PORT_OFF >> 3) && !reg_addr[0] && ch != 2'h3) begin
      src     = latched_reg[ch] ? latch_reg[ch] : count_reg[ch];
      hi      = (acc_reg[ch] == pacer_counters_pkg::ACC_HIGH) ||
                (acc_reg[ch] == pacer_counters_pkg::ACC_LOW_HIGH && rptr_reg[ch]);
      rd_byte = hi ? src[15:8] : src[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      rdata_reg <= `RDATA_RESET;
    else if (reg_rd)
      rdata_reg <= rd_byte;
  end

  // ----------------------------------------------------------
  // Pacer, pre-trigger and A/D trigger
  // ----------------------------------------------------------
  assign pacer_rise = out_reg[2] && !out2_prev_reg;
  assign pt_fall    = pt_prev_reg && !pretrigger_input;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out1_prev_reg <= 1'b1;
      out2_prev_reg <= 1'b1;
      pt_prev_reg   <= 1'b0;
    end else begin
      out1_prev_reg <= out_reg[1];
      out2_prev_reg <= out_reg[2];
      pt_prev_reg   <= pretrigger_input;
    end
  end

  // Gate set wins over the zero_reg clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst)
      gate0_reg <= 1'b0;
    else if (!pretrigger_mode_en)
      gate0_reg <= 1'b0;
    else if (pt_fall)
      gate0_reg <= 1'b1;
    else if (zero_reg[0])
      gate0_reg <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      stop_reg <= 1'b0;
    else if (!pretrigger_mode_en)
      stop_reg <= 1'b0;
    else if (zero_reg[0] && gate0_reg)
      stop_reg <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      ad_trig_reg <= 1'b0;
    else
      ad_trig_reg <= (ad_src_ext_sel ? ext_ad_trigger : pacer_rise) && !stop_reg;
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      irq2_reg <= 1'b0;
    else
      irq2_reg <= irq_src_pacer_sel ? out_reg[2] : ext_irq_input;
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign reg_rdata       = rdata_reg;
  assign ad_trigger      = ad_trig_reg;
  assign pacer_out       = out_reg[2];
  assign second_irq_line = irq2_reg;
  assign ad_stopped      = stop_reg;

endmodule // pacer_pretrigger_counters

// ==== testbench/pacer_counters_props.sv ====
// Port checker of the counter block, bound onto its top module.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ps
`include "pacer_counters_map.svh"

module pacer_counters_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Host port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic       ad_src_ext_sel,
  input wire logic       pretrigger_mode_en,
  input wire logic       irq_src_pacer_sel,
  input wire logic       ext_irq_input,
  input wire logic       ad_trigger,
  input wire logic       pacer_out,
  input wire logic       second_irq_line,
  input wire logic       ad_stopped
);
  logic irq_src;

  // Mux kept outside the property so that past sees a plain signal
  assign irq_src = irq_src_pacer_sel ? pacer_out : ext_irq_input;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  irq_mux_a: assert property ($past(nrst) |-> second_irq_line == $past(irq_src))
    else $error("irq line not following its source");
  pacer_trig_a: assert property (!ad_src_ext_sel && !ad_stopped && $rose(pacer_out) |=> ad_trigger)
    else $error("pacer edge gave no trigger");
  stop_block_a: assert property (ad_stopped && $past(ad_stopped) |-> !ad_trigger)
    else $error("trigger while stopped");
  mode_off_a: assert property (!pretrigger_mode_en |=> !ad_stopped)
    else $error("stop flag set outside pre-trigger mode");
  pacer_high_a: assert property ($rose(pacer_out) |-> pacer_out [*8])
    else $error("pacer high phase too short");
  pacer_low_a: assert property ($fell(pacer_out) |-> (!pacer_out) [*8])
    else $error("pacer low phase too short");
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  ctrl_rd_a: assert property (reg_rd && reg_addr == `CTRL_WORD_OFF |=> reg_rdata == `RDATA_RESET)
    else $error("control byte not write-only");
endmodule // pacer_counters_props

bind pacer_pretrigger_counters pacer_counters_props u_props (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ad_src_ext_sel(ad_src_ext_sel), .pretrigger_mode_en(pretrigger_mode_en),
  .irq_src_pacer_sel(irq_src_pacer_sel), .ext_irq_input(ext_irq_input), .ad_trigger(ad_trigger),
  .pacer_out(pacer_out), .second_irq_line(second_irq_line), .ad_stopped(ad_stopped)
);

// ==== testbench/test_pacer_pretrigger_counters.sv ====
// Self-checking bench: byte port, counter 0 by external triggers, pre-trigger stop, pacer.
// Assumes the map header on the include path; inputs move 2 ns after each rising edge.
`timescale 1ns/1ps
`include "pacer_counters_map.svh"

module test_pacer_pretrigger_counters;
  logic       clk, nrst, reg_wr, reg_rd, ad_src_ext_sel, ext_ad_trigger;
  logic       pretrigger_mode_en, pretrigger_input, irq_src_pacer_sel, ext_irq_input;
  logic       ad_trigger, pacer_out, second_irq_line, ad_stopped;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int         mismatches, n_tests, n_ad, cyc;

  pacer_pretrigger_counters dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ad_src_ext_sel(ad_src_ext_sel),
    .ext_ad_trigger(ext_ad_trigger), .pretrigger_mode_en(pretrigger_mode_en),
    .pretrigger_input(pretrigger_input), .irq_src_pacer_sel(irq_src_pacer_sel),
    .ext_irq_input(ext_irq_input), .ad_trigger(ad_trigger), .pacer_out(pacer_out),
    .second_irq_line(second_irq_line), .ad_stopped(ad_stopped)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard; a full run needs well under a tenth of this
  always @(posedge clk) begin
    cyc++;
    if (ad_trigger === 1'b1) n_ad++;
    if (cyc == 30000) begin
      mismatches++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    d = reg_rdata;
  endtask

  // Latch counter 0 and read two bytes
  task automatic rd0(output logic [15:0] v);
    wr(8'h46, 8'h00);
    rd(8'h40, v[7:0]);
    rd(8'h40, v[15:8]);
  endtask

  task automatic trig(input int n);
    repeat (n) begin
      ext_ad_trigger = 1'b1;
      step(1);
      ext_ad_trigger = 1'b0;
      step(4);
    end
  endtask

  task automatic arm();
    pretrigger_mode_en = 1'b1;
    step(1);
    pretrigger_input = 1'b0;
    step(2);
    pretrigger_input = 1'b1;
    step(1);
  endtask

  task automatic rise();
    logic p;
    int   k;
    p = pacer_out;
    k = 0;
    while (!(p === 1'b0 && pacer_out === 1'b1) && k < 2000) begin
      p = pacer_out;
      step(1);
      k++;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    rd(8'h46, d);
    chk({8'h00, d}, 16'h0000);
    wr(8'h50, 8'hff);
    rd(8'h50, d);
    chk({8'h00, d}, 16'h0000);
    chk({15'h0, pacer_out}, 16'h0001);
    $display("reset test done");
  endtask

  // Pointer reset by a control write; an illegal select leaves it alone
  task automatic t_ptr();
    logic [15:0] v;
    wr(8'h46, 8'h30);
    wr(8'h40, 8'h55);
    wr(8'h46, 8'h30);
    wr(8'h40, 8'h09);
    wr(8'h46, 8'hf1);
    wr(8'h40, 8'h00);
    trig(1);
    rd0(v);
    chk(v, 16'h0009);
    $display("pointer test done");
  endtask

  // First trigger loads with gate low; counting starts after the fall
  task automatic t_cnt(input logic [7:0] ctl, b0, b1, input int nb, ntr, input logic [15:0] e0, e1);
    logic [15:0] v;
    wr(8'h46, ctl);
    wr(8'h40, b0);
    if (nb == 2) wr(8'h40, b1);
    trig(1);
    rd0(v);
    chk(v, e0);
    arm();
    trig(ntr);
    rd0(v);
    chk(v, e1);
    pretrigger_mode_en = 1'b0;
    step(2);
    $display("count test %h done", ctl);
  endtask

  task automatic t_pretrig();
    int a0;
    wr(8'h46, 8'h30);
    wr(8'h40, 8'h03);
    wr(8'h40, 8'h00);
    trig(1);
    pretrigger_mode_en = 1'b1;
    trig(2);
    arm();
    a0 = n_ad;
    trig(2);
    chk({15'h0, ad_stopped}, 16'h0000);
    trig(1);
    step(4);
    chk({15'h0, ad_stopped}, 16'h0001);
    trig(1);
    chk(16'(n_ad - a0), 16'h0003);
    pretrigger_mode_en = 1'b0;
    step(2);
    chk({15'h0, ad_stopped}, 16'h0000);
    $display("pre-trigger test done");
  endtask

  task automatic t_irq();
    ext_irq_input = 1'b1;
    step(2);
    chk({15'h0, second_irq_line}, 16'h0001);
    ext_irq_input = 1'b0;
    step(2);
    chk({15'h0, second_irq_line}, 16'h0000);
    irq_src_pacer_sel = 1'b1;
    $display("irq test done");
  endtask

  // Counter 2 first, so its control write never cuts a low phase short
  task automatic t_pacer(input logic [7:0] c1, c2, n1, n2);
    int t0, a0;
    ad_src_ext_sel = 1'b0;
    wr(8'h46, c2);
    wr(8'h44, n2);
    wr(8'h44, 8'h00);
    wr(8'h46, c1);
    wr(8'h42, n1);
    wr(8'h42, 8'h00);
    rise();
    rise();
    t0 = cyc;
    a0 = n_ad;
    rise();
    chk(16'(cyc - t0), 16'(n1 * n2 * `BASE_DIV));
    chk(16'(n_ad - a0), 16'h0001);
    $display("pacer test %h done", c1);
  endtask

  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ad_src_ext_sel = 1'b1;
    ext_ad_trigger = 1'b0;
    pretrigger_mode_en = 1'b0;
    pretrigger_input = 1'b1;
    irq_src_pacer_sel = 1'b0;
    ext_irq_input = 1'b0;
    step(12);
    nrst = 1'b1;
    t_reset();
    t_ptr();
    t_cnt(8'h30, 8'h09, 8'h01, 2, 2, 16'h0109, 16'h0107);
    t_cnt(8'h31, 8'h00, 8'h01, 2, 2, 16'h0100, 16'h0098);
    t_cnt(8'h10, 8'h20, 8'h00, 1, 2, 16'h2020, 16'h1e1e);
    t_cnt(8'h20, 8'h01, 8'h00, 1, 2, 16'h0101, 16'h0000);
    t_cnt(8'h3c, 8'h03, 8'h00, 2, 3, 16'h0003, 16'h0003);
    t_cnt(8'h36, 8'h04, 8'h00, 2, 1, 16'h0004, 16'h0002);
    t_cnt(8'h38, 8'h05, 8'h00, 2, 2, 16'h0005, 16'h0003);
    t_pretrig();
    t_irq();
    t_pacer(8'h74, 8'hb4, 8'h02, 8'h02);
    rise();
    t_pacer(8'h7c, 8'hbc, 8'h03, 8'h05);
    test_done();
  end
endmodule // test_pacer_pretrigger_counters
